// ==== psw_pkg.sv ====
// Behaviour
// - status1 bit0: ready to start, pulses inhibited
// - status1 bit1: switched on, no fault
// - status1 bit2: operation enabled, follows setpoint
// - status1 bit3: fault present, acknowledge clears
// - status1 bit4: coast stop not active
// - status1 bit5: quick stop not active
// - status1 bit6: lockout until ramp stop, on
// - status1 bit7: alarm present, no acknowledge
// - status1 bit8: following error within tolerance
// - status1 bit9: control requested from automation
// - status1 bit10: target position reached
// - status1 bit11: axis referenced
// - status1 bit12 rises: traversing block acknowledged
// - status1 bit13: setpoint stationary
// - control2 bits1:0 select drive parameter set
// - control2 bit7 selects parking axis
// - control2 bits15:12 carry master life counter
// - status2 bits1:0 effective parameter set
// - status2 bits6:5 alarm class
// - status2 bit8 travel to fixed stop
// - status2 bits15:12 slave life counter
package psw_pkg;
   localparam int WORD_W = 16;
   localparam int LIFE_W = 4;
   // control word one bit positions
   localparam int C1_ON = 0;
   localparam int C1_NO_COAST = 1;
   localparam int C1_NO_QUICK = 2;
   localparam int C1_ENABLE = 3;
   localparam int C1_ACK = 7;
   // control word two fields
   localparam int C2_SET_LO = 0;
   localparam int C2_PARK = 7;
   localparam int C2_LIFE_LO = 12;
   // status word one bit positions
   localparam int S1_RTS = 0;
   localparam int S1_READY = 1;
   localparam int S1_ENABLED = 2;
   localparam int S1_FAULT = 3;
   localparam int S1_NO_COAST = 4;
   localparam int S1_NO_QUICK = 5;
   localparam int S1_LOCKOUT = 6;
   localparam int S1_ALARM = 7;
   localparam int S1_FOLLOW_OK = 8;
   localparam int S1_CTRL_REQ = 9;
   localparam int S1_TARGET = 10;
   localparam int S1_REFERENCED = 11;
   localparam int S1_BLOCK_ACK = 12;
   localparam int S1_STILL = 13;
   // status word two fields
   localparam int S2_SET_LO = 0;
   localparam int S2_CLASS_LO = 5;
   localparam int S2_FIXED_STOP = 8;
   localparam int S2_PULSES = 10;
   localparam int S2_LIFE_LO = 12;
   // controller register map, byte addresses
   localparam logic [7:0] REG_CTL_FIRST = 8'h00;
   localparam logic [7:0] REG_CTL_SECOND = 8'h04;
   localparam logic [7:0] REG_STAT_FIRST = 8'h08;
   localparam logic [7:0] REG_STAT_SECOND = 8'h0c;
   localparam logic [7:0] REG_LIFE = 8'h10;
   localparam logic [7:0] REG_PERIOD = 8'h14;
   // reset values and control word two write mask
   localparam logic [15:0] CTL_FIRST_RST = 16'h0000;
   localparam logic [15:0] CTL_SECOND_RST = 16'h0000;
   localparam logic [15:0] PERIOD_RST = 16'h0064;
   localparam logic [15:0] CTL_SECOND_MASK = 16'h0083;
   // drive states, gray along lockout-start-ready-enabled
   typedef enum logic [2:0] {
      ST_LOCK = 3'h0,
      ST_START = 3'h1,
      ST_READY = 3'h3,
      ST_ENABLED = 3'h2,
      ST_FAULT = 3'h6
   } psw_state_e;
endpackage

// ==== psw_link_if.sv ====
`timescale 1ns/1ps
// cyclic telegram exchange between controller and drive
interface psw_link_if;
   logic tel_strobe;
   logic [15:0] ctl_first;
   logic [15:0] ctl_second;
   logic stat_valid;
   logic [15:0] stat_first;
   logic [15:0] stat_second;
   modport dev (
      input tel_strobe,
      input ctl_first,
      input ctl_second,
      output stat_valid,
      output stat_first,
      output stat_second
   );
   modport ctl (
      output tel_strobe,
      output ctl_first,
      output ctl_second,
      input stat_valid,
      input stat_first,
      input stat_second
   );
endinterface

// ==== psw_drive_end.sv ====
`timescale 1ns/1ps
module psw_drive_end
   import psw_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // telegram link
   psw_link_if.dev LINK,
   // drive state inputs
   input wire logic ELECTRONICS_READY,
   input wire logic FAULT_IN,
   input wire logic ALARM_IN,
   input wire logic [1:0] ALARM_CLASS,
   input wire logic FOLLOW_ERR_OK,
   input wire logic CONTROL_REQUEST,
   input wire logic TARGET_REACHED,
   input wire logic REFERENCED,
   input wire logic BLOCK_ACTIVE,
   input wire logic SETPOINT_STILL,
   input wire logic FIXED_STOP_TRAVEL,
   // drive command outputs
   output logic PULSES_ENABLED,
   output logic [1:0] PARAM_SET,
   output logic PARK_AXIS,
   output logic MASTER_LIFE_FAULT
);
   psw_state_e state_reg;
   psw_state_e state_next;
   logic fault_reg;
   logic ack_prev_reg;
   logic [1:0] set_reg;
   logic park_reg;
   logic [LIFE_W-1:0] slave_life_reg;
   logic [LIFE_W-1:0] master_prev_reg;
   logic master_seen_reg;
   logic life_fault_reg;
   logic valid_reg;
   logic [15:0] stat1_reg;
   logic [15:0] stat2_reg;
   logic block_prev_reg;

   // control word fields, taken only while the strobe is high
   wire tel = LINK.tel_strobe;
   wire cmd_on = LINK.ctl_first[C1_ON];
   wire no_coast = LINK.ctl_first[C1_NO_COAST];
   wire no_quick = LINK.ctl_first[C1_NO_QUICK];
   wire cmd_enable = LINK.ctl_first[C1_ENABLE];
   wire ack_bit = LINK.ctl_first[C1_ACK];
   wire ack_rise = tel && ack_bit && !ack_prev_reg;
   wire stops_ok = no_coast && no_quick;
   wire [1:0] set_sel = LINK.ctl_second[C2_SET_LO +: 2];
   wire [LIFE_W-1:0] master_life = LINK.ctl_second[C2_LIFE_LO +: LIFE_W];
   wire [LIFE_W-1:0] master_expect = master_prev_reg + 4'h1;
   wire life_bad = master_seen_reg && (master_life != master_expect);

   // the stop commands last received, needed for stop flags between telegrams
   logic coast_seen_reg;
   logic quick_seen_reg;

   // drive state sequence, stepped by commands once per telegram, by a fault or lost electronics in any cycle
   always_comb begin
      state_next = state_reg;
      if (!ELECTRONICS_READY) begin
         state_next = ST_LOCK;
      end else if (fault_reg) begin
         state_next = ST_FAULT;
      end else if (tel) begin
         case (state_reg)
            ST_FAULT: begin
               state_next = ST_LOCK;
            end
            ST_LOCK: begin
               // leave lockout only with the on command withdrawn
               if (!cmd_on && stops_ok) begin
                  state_next = ST_START;
               end
            end
            ST_START: begin
               if (!stops_ok) begin
                  state_next = ST_LOCK;
               end else if (cmd_on) begin
                  state_next = ST_READY;
               end
            end
            ST_READY: begin
               if (!stops_ok) begin
                  state_next = ST_LOCK;
               end else if (!cmd_on) begin
                  state_next = ST_START;
               end else if (cmd_enable) begin
                  state_next = ST_ENABLED;
               end
            end
            ST_ENABLED: begin
               if (!stops_ok) begin
                  state_next = ST_LOCK;
               end else if (!cmd_on) begin
                  state_next = ST_START;
               end else if (!cmd_enable) begin
                  state_next = ST_READY;
               end
            end
            default: begin
               state_next = ST_LOCK;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_reg <= ST_LOCK;
      end else begin
         state_reg <= state_next;
      end
   end

   // fault latch: a new fault wins over an acknowledge in the same cycle
   wire fault_next = FAULT_IN || (fault_reg && !ack_rise);

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         fault_reg <= 1'b0;
         ack_prev_reg <= 1'b0;
      end else begin
         fault_reg <= fault_next;
         if (tel) begin
            ack_prev_reg <= ack_bit;
         end
      end
   end

   // stop commands held from the last telegram
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         coast_seen_reg <= 1'b0;
         quick_seen_reg <= 1'b0;
      end else if (tel) begin
         coast_seen_reg <= no_coast;
         quick_seen_reg <= no_quick;
      end
   end

   // parameter set changes only while pulses are off, avoiding a switch
   // of motor data under current
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         set_reg <= 2'h0;
         park_reg <= 1'b0;
      end else if (tel) begin
         park_reg <= LINK.ctl_second[C2_PARK];
         if (state_reg != ST_ENABLED) begin
            set_reg <= set_sel;
         end
      end
   end

   // slave counter advances and master counter is checked per telegram
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         slave_life_reg <= 4'h0;
         master_prev_reg <= 4'h0;
         master_seen_reg <= 1'b0;
         life_fault_reg <= 1'b0;
      end else if (tel) begin
         slave_life_reg <= slave_life_reg + 4'h1;
         master_prev_reg <= master_life;
         master_seen_reg <= 1'b1;
         life_fault_reg <= life_bad;
      end
   end

   // status word one built from the state before this telegram
   logic [15:0] s1;
   logic [15:0] s2;
   always_comb begin
      s1 = 16'h0000;
      s1[S1_RTS] = (state_reg == ST_START);
      s1[S1_READY] = (state_reg == ST_READY) ||
                     (state_reg == ST_ENABLED);
      s1[S1_ENABLED] = (state_reg == ST_ENABLED);
      s1[S1_FAULT] = fault_reg;
      s1[S1_NO_COAST] = coast_seen_reg;
      s1[S1_NO_QUICK] = quick_seen_reg;
      s1[S1_LOCKOUT] = (state_reg == ST_LOCK);
      s1[S1_ALARM] = ALARM_IN;
      s1[S1_FOLLOW_OK] = FOLLOW_ERR_OK;
      s1[S1_CTRL_REQ] = CONTROL_REQUEST;
      s1[S1_TARGET] = TARGET_REACHED;
      s1[S1_REFERENCED] = REFERENCED;
      s1[S1_BLOCK_ACK] = block_prev_reg;
      s1[S1_STILL] = SETPOINT_STILL;
   end

   // status word two; alarm class reads zero with no alarm pending
   always_comb begin
      s2 = 16'h0000;
      s2[S2_SET_LO +: 2] = set_reg;
      s2[S2_CLASS_LO +: 2] = ALARM_IN ? ALARM_CLASS : 2'h0;
      s2[S2_FIXED_STOP] = FIXED_STOP_TRAVEL;
      s2[S2_PULSES] = (state_reg == ST_ENABLED);
      s2[S2_LIFE_LO +: LIFE_W] = slave_life_reg;
   end

   // reply one cycle after each telegram; block flag follows the input
   // so a fresh block shows as a rising edge at the controller
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         valid_reg <= 1'b0;
         stat1_reg <= 16'h0000;
         stat2_reg <= 16'h0000;
         block_prev_reg <= 1'b0;
      end else begin
         valid_reg <= tel;
         block_prev_reg <= BLOCK_ACTIVE;
         if (tel) begin
            stat1_reg <= s1;
            stat2_reg <= s2;
         end
      end
   end

   assign LINK.stat_valid = valid_reg;
   assign LINK.stat_first = stat1_reg;
   assign LINK.stat_second = stat2_reg;

   // drive command outputs
   logic pulses_reg;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pulses_reg <= 1'b0;
      end else begin
         pulses_reg <= (state_next == ST_ENABLED);
      end
   end

   assign PULSES_ENABLED = pulses_reg;
   assign PARAM_SET = set_reg;
   assign PARK_AXIS = park_reg;
   assign MASTER_LIFE_FAULT = life_fault_reg;
endmodule

// ==== psw_ctrl_end.sv ====
`timescale 1ns/1ps
module psw_ctrl_end
   import psw_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // telegram link
   psw_link_if.ctl LINK,
   // software register port
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA
);
   logic [15:0] ctl1_reg;
   logic [15:0] ctl2_reg;
   logic [15:0] stat1_reg;
   logic [15:0] stat2_reg;
   logic [15:0] period_reg;
   logic [15:0] count_reg;
   logic strobe_reg;
   logic [LIFE_W-1:0] master_life_reg;
   logic [LIFE_W-1:0] slave_prev_reg;
   logic slave_seen_reg;
   logic life_err_reg;
   logic [15:0] rdata_reg;

   // address decode
   wire wr_c1 = WR && (ADDR == REG_CTL_FIRST);
   wire wr_c2 = WR && (ADDR == REG_CTL_SECOND);
   wire wr_life = WR && (ADDR == REG_LIFE);
   wire wr_per = WR && (ADDR == REG_PERIOD);
   wire [LIFE_W-1:0] slave_life = LINK.stat_second[S2_LIFE_LO +: LIFE_W];
   wire [LIFE_W-1:0] slave_expect = slave_prev_reg + 4'h1;
   wire slave_bad = LINK.stat_valid && slave_seen_reg &&
                    (slave_life != slave_expect);
   wire tick = (count_reg == 16'h0000);

   // software registers; a period of zero sends every cycle
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctl1_reg <= CTL_FIRST_RST;
         ctl2_reg <= CTL_SECOND_RST;
         period_reg <= PERIOD_RST;
      end else begin
         if (wr_c1) begin
            ctl1_reg <= WDATA;
         end
         if (wr_c2) begin
            ctl2_reg <= WDATA & CTL_SECOND_MASK;
         end
         if (wr_per) begin
            period_reg <= WDATA;
         end
      end
   end

   // telegram timer and master counter
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         count_reg <= 16'h0000;
         strobe_reg <= 1'b0;
         master_life_reg <= 4'h0;
      end else begin
         strobe_reg <= tick;
         count_reg <= tick ? period_reg : count_reg - 16'h0001;
         if (strobe_reg) begin
            master_life_reg <= master_life_reg + 4'h1;
         end
      end
   end

   // status capture; a stalled slave counter wins over a clear
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         stat1_reg <= 16'h0000;
         stat2_reg <= 16'h0000;
         slave_prev_reg <= 4'h0;
         slave_seen_reg <= 1'b0;
         life_err_reg <= 1'b0;
      end else begin
         if (LINK.stat_valid) begin
            stat1_reg <= LINK.stat_first;
            stat2_reg <= LINK.stat_second;
            slave_prev_reg <= slave_life;
            slave_seen_reg <= 1'b1;
         end
         life_err_reg <= slave_bad || (life_err_reg &&
                         !(wr_life && WDATA[0]));
      end
   end

   // read mux, data valid the cycle after the strobe
   logic [15:0] rd_mux;
   always_comb begin
      case (ADDR)
         REG_CTL_FIRST: rd_mux = ctl1_reg;
         REG_CTL_SECOND: rd_mux = ctl2_reg;
         REG_STAT_FIRST: rd_mux = stat1_reg;
         REG_STAT_SECOND: rd_mux = stat2_reg;
         REG_LIFE: rd_mux = {15'h0000, life_err_reg};
         REG_PERIOD: rd_mux = period_reg;
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_reg <= 16'h0000;
      end else begin
         rdata_reg <= RD ? rd_mux : 16'h0000;
      end
   end

   assign RDATA = rdata_reg;
   assign LINK.tel_strobe = strobe_reg;
   assign LINK.ctl_first = ctl1_reg;
   assign LINK.ctl_second = {master_life_reg, ctl2_reg[11:0]};
endmodule

// ==== psw_monitor.sv ====
`timescale 1ns/1ps
module psw_monitor
   import psw_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // telegram link
   input wire logic tel_strobe,
   input wire logic [15:0] ctl_first,
   input wire logic [15:0] ctl_second,
   input wire logic stat_valid,
   input wire logic [15:0] stat_first,
   input wire logic [15:0] stat_second
);
   logic [3:0] slife_reg;
   logic [3:0] mlife_reg;
   logic sseen_reg;
   logic mseen_reg;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // last life counts; the first telegram after reset has no step to check
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         slife_reg <= 4'h0;
         mlife_reg <= 4'h0;
         sseen_reg <= 1'b0;
         mseen_reg <= 1'b0;
      end else begin
         if (stat_valid) slife_reg <= stat_second[15:12];
         if (stat_valid) sseen_reg <= 1'b1;
         if (tel_strobe) mlife_reg <= ctl_second[15:12];
         if (tel_strobe) mseen_reg <= 1'b1;
      end
   end
   // link timing, life counts and the status and control words themselves
   a_reply_one_later: assert property (
      tel_strobe |=> stat_valid)
      else $error("no reply one cycle after telegram");
   a_reply_has_cause: assert property (
      stat_valid |-> $past(tel_strobe))
      else $error("reply without telegram");
   a_status_held: assert property (
      !stat_valid |-> $stable(stat_first) && $stable(stat_second))
      else $error("status words moved between replies");
   a_slave_life_first: assert property (
      stat_valid && !sseen_reg |-> stat_second[15:12] == 4'h0)
      else $error("first slave life count not zero");
   a_slave_life_step: assert property (
      stat_valid && sseen_reg |->
      stat_second[15:12] == slife_reg + 4'h1)
      else $error("slave life count did not step by one");
   a_master_life_step: assert property (
      tel_strobe && mseen_reg |->
      ctl_second[15:12] == mlife_reg + 4'h1)
      else $error("master life count did not step by one");
   a_ctl2_spare_zero: assert property (
      tel_strobe |-> ctl_second[11:8] == 4'h0 &&
      ctl_second[6:2] == 5'h00)
      else $error("spare control word two bits set");
   a_enabled_pulses: assert property (
      stat_second[S2_PULSES] == stat_first[S1_ENABLED])
      else $error("pulse flag disagrees with enabled flag");
   a_enabled_needs_ready: assert property (
      stat_first[S1_ENABLED] |->
      stat_first[S1_READY] && !stat_first[S1_FAULT])
      else $error("enabled without ready or with fault");
   a_lockout_alone: assert property (
      stat_first[S1_LOCKOUT] |-> stat_first[2:0] == 3'h0)
      else $error("lockout together with a start state");
   // main scenarios
   c_enabled: cover property (stat_valid && stat_first[S1_ENABLED]);
   c_fault: cover property (stat_valid && stat_first[S1_FAULT]);
   c_ack: cover property (tel_strobe && ctl_first[C1_ACK]);
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb import psw_pkg::*;;
   logic clk, reset_n, wr, rd, elec_ready, fault_in;
   logic [7:0] addr, v;
   logic [15:0] wdata, rdata, d;
   logic [1:0] param_set;
   logic [1:0] aclass;
   logic pulses_enabled, park_axis, master_life_fault;
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   psw_link_if link();
   psw_ctrl_end psw_ctrl_end_inst (.CLK(clk), .RESET_N(reset_n), .LINK(link),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
   // v packs alarm, follow, request, target, referenced, block, still, stop
   psw_drive_end psw_drive_end_inst (.CLK(clk), .RESET_N(reset_n),
      .LINK(link), .ELECTRONICS_READY(elec_ready), .FAULT_IN(fault_in),
      .ALARM_IN(v[0]), .ALARM_CLASS(aclass), .FOLLOW_ERR_OK(v[1]),
      .CONTROL_REQUEST(v[2]), .TARGET_REACHED(v[3]), .REFERENCED(v[4]),
      .BLOCK_ACTIVE(v[5]), .SETPOINT_STILL(v[6]), .FIXED_STOP_TRAVEL(v[7]),
      .PULSES_ENABLED(pulses_enabled), .PARAM_SET(param_set),
      .PARK_AXIS(park_axis), .MASTER_LIFE_FAULT(master_life_fault));
   psw_monitor psw_monitor_inst (.CLK(clk), .RESET_N(reset_n),
      .tel_strobe(link.tel_strobe), .ctl_first(link.ctl_first),
      .ctl_second(link.ctl_second), .stat_valid(link.stat_valid),
      .stat_first(link.stat_first), .stat_second(link.stat_second));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (err_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] x);
      @(posedge clk);
      addr <= a;
      wdata <= x;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // status shows the state before a telegram's commands, so wait n replies;
   // returns on a rising edge so that inputs may be driven there
   task automatic sync(input int n);
      int c;
      c = 0;
      while (c < n) begin
         @(posedge clk);
         #1;
         if (link.stat_valid === 1'b1) c++;
      end
      @(posedge clk);
   endtask
   // hang guard, well above the longest sequence
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         test_done();
      end
   end
   initial begin
      reset_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      elec_ready = 1'b1;
      fault_in = 1'b0;
      v = 8'h00;
      aclass = 2'h0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      rd_reg(REG_PERIOD);
      chk(d, PERIOD_RST);
      wr_reg(REG_PERIOD, 16'h0004);
      rd_reg(REG_PERIOD);
      chk(d, 16'h0004);
      wr_reg(8'h20, 16'hffff);
      rd_reg(8'h20);
      chk(d, 16'h0000);
      wr_reg(REG_CTL_SECOND, 16'hffff);
      rd_reg(REG_CTL_SECOND);
      chk(d, CTL_SECOND_MASK);
      sync(2);
      rd_reg(REG_STAT_FIRST);
      chk(d & 16'h007f, 16'h0040);
      wr_reg(REG_CTL_FIRST, 16'h0006);
      sync(2);
      rd_reg(REG_STAT_FIRST);
      chk(d & 16'h007f, 16'h0031);
      // every parameter set code, park flag alternating
      for (int k = 0; k < 4; k++) begin
         wr_reg(REG_CTL_SECOND, {8'h00, k[0], 5'h00, k[1:0]});
         sync(2);
         rd_reg(REG_STAT_SECOND);
         chk(d & 16'h0003, {14'h0, k[1:0]});
         chk({14'h0, param_set}, {14'h0, k[1:0]});
         chk({15'h0, park_axis}, {15'h0, k[0]});
      end
      wr_reg(REG_CTL_FIRST, 16'h0007);
      sync(2);
      rd_reg(REG_STAT_FIRST);
      chk(d & 16'h007f, 16'h0032);
      wr_reg(REG_CTL_FIRST, 16'h000f);
      sync(2);
      rd_reg(REG_STAT_FIRST);
      chk(d & 16'h007f, 16'h0036);
      chk({15'h0, pulses_enabled}, 16'h0001);
      wr_reg(REG_CTL_SECOND, 16'h0001);
      sync(2);
      chk({14'h0, param_set}, 16'h0003);
      // even steps raise the alarm, each with another class code
      foreach (v[i]) begin
         @(posedge clk);
         v <= i[0] ? 8'haa : 8'h55;
         aclass <= 2'(i >> 1);
         sync(2);
         rd_reg(REG_STAT_FIRST);
         chk(d & 16'h0180, {7'h0, v[1], v[0], 7'h00});
         chk(d & 16'h3e00, {2'h0, v[6:2], 9'h000});
         rd_reg(REG_STAT_SECOND);
         chk(d & 16'h0100, {7'h0, v[7], 8'h00});
         chk(d & 16'h0060, {9'h0, (v[0] ? aclass : 2'h0), 5'h00});
      end
      @(posedge clk);
      fault_in <= 1'b1;
      sync(2);
      fault_in <= 1'b0;
      chk({15'h0, pulses_enabled}, 16'h0000);
      sync(2);
      rd_reg(REG_STAT_FIRST);
      chk(d & 16'h000f, 16'h0008);
      wr_reg(REG_CTL_FIRST, 16'h008f);
      sync(4);
      rd_reg(REG_STAT_FIRST);
      chk(d & 16'h004f, 16'h0040);
      wr_reg(REG_CTL_FIRST, 16'h0006);
      sync(2);
      rd_reg(REG_STAT_FIRST);
      chk(d & 16'h0043, 16'h0001);
      wr_reg(REG_CTL_FIRST, 16'h0007);
      sync(2);
      rd_reg(REG_STAT_FIRST);
      chk(d & 16'h0043, 16'h0002);
      @(posedge clk);
      elec_ready <= 1'b0;
      sync(2);
      rd_reg(REG_STAT_FIRST);
      chk(d & 16'h0047, 16'h0040);
      rd_reg(REG_LIFE);
      chk(d & 16'h0001, 16'h0000);
      chk({15'h0, master_life_fault}, 16'h0000);
      wr_reg(REG_LIFE, 16'h0001);
      rd_reg(REG_LIFE);
      chk(d, 16'h0000);
      // second reset in mid-run restarts both life counts
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      sync(3);
      chk({15'h0, master_life_fault}, 16'h0000);
      // third reply after reset carries slave count two and set zero
      rd_reg(REG_STAT_SECOND);
      chk(d & 16'hf003, 16'h2000);
      test_done();
   end
endmodule
